// file: rtl/ctm_channel.sv
// channel front end: input selector, oscillator, mixer and comb decimator
`timescale 1ns/1ns
`include "ctm_defines.svh"
module ctm_channel (
    input  wire logic                       CLK,
    input  wire logic                       RST_N,
    input  wire logic                       IN_VALID,
    input  wire ctm_pkg::ctm_port_s         PORT_A,
    input  wire ctm_pkg::ctm_port_s         PORT_B,
    input  wire ctm_pkg::ctm_port_s         PORT_C,
    input  wire ctm_pkg::ctm_port_s         PORT_D,
    input  wire logic                       COMPLEX_INPUT,
    input  wire logic [2:0]                 XBAR_SEL,
    input  wire logic                       TUNE_WR,
    input  wire logic [31:0]                TUNE_WDATA,
    input  wire logic [15:0]                HOLDOFF,
    input  wire logic [15:0]                PHASE_OFFSET,
    input  wire logic                       OSC_BYPASS,
    input  wire logic                       CLEAR_ACC,
    input  wire logic                       PHASE_DITHER_EN,
    input  wire logic                       AMP_DITHER_EN,
    input  wire logic                       SLEEP_EXIT,
    input  wire logic                       HOP_SYNC,
    input  wire logic [4:0]                 CIC_DECIM,
    input  wire logic [4:0]                 CIC_SCALE,
    input  wire logic                       CIC_BYPASS,
    output logic      [31:0]                ACTIVE_TUNING_WORD,
    output logic                            UPDATE_PENDING,
    output logic                            OUT_VALID,
    output ctm_pkg::ctm_iq_s                OUT_IQ,
    output logic      [2:0]                 OUT_EXP
);
    import ctm_pkg::*;

    localparam int MW = `CTM_MAG_W;
    localparam int AW = `CTM_AMP_W;
    localparam int XW = `CTM_MIX_W;

    // picks one real port by its two-bit index
    function automatic ctm_port_s pick_port(
        input logic [1:0] idx,
        input ctm_port_s  a,
        input ctm_port_s  b,
        input ctm_port_s  c,
        input ctm_port_s  d
    );
        case (idx)
            2'h0:    pick_port = a;
            2'h1:    pick_port = b;
            2'h2:    pick_port = c;
            default: pick_port = d;
        endcase
    endfunction : pick_port

    // half-wave parabola sine from 18 phase bits, 17-bit signed amplitude
    function automatic logic signed [AW-1:0] osc_sin(
        input logic [`CTM_LUT_W-1:0] p
    );
        logic [AW-1:0]   x;
        logic [AW:0]     xc;
        logic [2*AW:0]   y;
        logic [AW-1:0]   m;
        x  = p[AW-1:0];
        xc = `CTM_HALF_TURN - {1'b0, x};
        y  = (2*AW+1)'(x) * (2*AW+1)'(xc);
        m  = (y[2*AW:AW-1] > (AW+2)'(`CTM_AMP_MAX)) ? `CTM_AMP_MAX
                                                     : y[AW+AW-2:AW-1];
        osc_sin = p[`CTM_LUT_W-1] ? -$signed(m) : $signed(m);
    endfunction : osc_sin

    // shadow, active word, hold-off and accumulator state
    logic [`CTM_TW_W-1:0]    shadow_q;
    logic [`CTM_TW_W-1:0]    active_q;
    logic [`CTM_TW_W-1:0]    acc_q;
    logic [`CTM_HOLD_W-1:0]  hold_q;
    ctm_hold_e               hold_st_q;
    logic [`CTM_LFSR_W-1:0]  lfsr_q;

    // selected sample, registered once
    logic signed [MW-1:0]    s_i_q;
    logic signed [MW-1:0]    s_q_q;
    logic [`CTM_EXP_W-1:0]   s_exp_q;
    logic                    s_cpx_q;
    logic                    s_vld_q;

    // mixer output register
    ctm_iq_s                 mix_q;
    logic                    mix_vld_q;
    logic [`CTM_EXP_W-1:0]   mix_exp_q;

    // pseudorandom source and dither bits
    logic                    lfsr_fb;
    ctm_port_s               pn_i;
    ctm_port_s               pn_q;

    assign lfsr_fb = ^(lfsr_q & `CTM_LFSR_TAPS);
    assign pn_i    = '{mag: $signed(lfsr_q), exp: '0};
    assign pn_q    = '{mag: $signed({lfsr_q[7:0], lfsr_q[15:8]}), exp: '0};

    ctm_port_s   real_pick;
    ctm_port_s   sel_i;
    ctm_port_s   sel_q;
    logic        sel_cpx;

    assign real_pick = pick_port(XBAR_SEL[1:0], PORT_A, PORT_B, PORT_C,
                                 PORT_D);
    assign sel_cpx   = COMPLEX_INPUT &&
                       (XBAR_SEL <= `CTM_SEL_CPX_PN);
    assign sel_i = COMPLEX_INPUT ?
        ((XBAR_SEL == `CTM_SEL_CPX_AB) ? PORT_A :
         (XBAR_SEL == `CTM_SEL_CPX_CD) ? PORT_C :
         (XBAR_SEL == `CTM_SEL_CPX_PN) ? pn_i : '0) :
        ((XBAR_SEL <= `CTM_SEL_D) ? real_pick :
         (XBAR_SEL == `CTM_SEL_PN) ? pn_i : '0);
    assign sel_q = COMPLEX_INPUT ?
        ((XBAR_SEL == `CTM_SEL_CPX_AB) ? PORT_B :
         (XBAR_SEL == `CTM_SEL_CPX_CD) ? PORT_D :
         (XBAR_SEL == `CTM_SEL_CPX_PN) ? pn_q : '0) : '0;

    // oscillator phase
    logic [`CTM_PH_W-1:0]    ph20;
    logic [`CTM_LUT_W-1:0]   ph18;
    logic signed [AW-1:0]    sin_raw;
    logic signed [AW-1:0]    cos_raw;
    logic signed [AW-1:0]    sin_v;
    logic signed [AW-1:0]    cos_v;
    logic [AW-1:0]           adith;

    assign ph20 = acc_q[`CTM_TW_W-1:`CTM_PH_LSB] +
                  {PHASE_OFFSET, `CTM_OFS_PAD};
    // 18 bits of the offset phase address the generator
    assign ph18    = ph20[`CTM_PH_W-1:`CTM_PH_W-`CTM_LUT_W];
    assign sin_raw = osc_sin(ph18);
    assign cos_raw = osc_sin(ph18 + `CTM_QTR_TURN);
    // amplitude dither, independent of phase dither
    assign adith   = AMP_DITHER_EN ?
                     AW'(lfsr_q[`CTM_ADITH_W-1:0]) : '0;
    assign sin_v   = sin_raw + $signed(adith);
    assign cos_v   = cos_raw + $signed(adith);

    // mixing with cos - j sin
    logic signed [MW+AW:0]   p_ic;
    logic signed [MW+AW:0]   p_is;
    logic signed [MW+AW:0]   p_qc;
    logic signed [MW+AW:0]   p_qs;
    logic signed [MW+AW:0]   m_i;
    logic signed [MW+AW:0]   m_q;
    ctm_iq_s                 mix_d;

    assign p_ic = (MW+AW+1)'(s_i_q * cos_v);
    assign p_is = (MW+AW+1)'(s_i_q * sin_v);
    assign p_qc = (MW+AW+1)'(s_q_q * cos_v);
    assign p_qs = (MW+AW+1)'(s_q_q * sin_v);
    assign m_i  = s_cpx_q ? p_ic + p_qs : p_ic;
    assign m_q  = s_cpx_q ? p_qc - p_is : -p_is;
    // bypass sends first port to I and second to Q
    assign mix_d.i = OSC_BYPASS ? XW'(s_i_q)
                                : m_i[`CTM_MIX_LSB+XW-1:`CTM_MIX_LSB];
    assign mix_d.q = OSC_BYPASS ? XW'(s_q_q)
                                : m_q[`CTM_MIX_LSB+XW-1:`CTM_MIX_LSB];

    // update events and hold-off decisions
    logic update_evt;
    logic hold_now;
    logic hold_done;

    assign update_evt = SLEEP_EXIT || HOP_SYNC;
    assign hold_now   = HOLDOFF <= `CTM_HOLD_ONE;
    assign hold_done  = (hold_st_q == HOLD_COUNT) && IN_VALID &&
                        (hold_q <= `CTM_HOLD_ONE);

    // host writes only reach the shadow copy
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shadow_q <= `CTM_TW_RESET;
        end else if (TUNE_WR) begin
            shadow_q <= TUNE_WDATA;
        end
    end

    // hold-off counter runs on selected input samples
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_st_q <= HOLD_IDLE;
            hold_q    <= '0;
            active_q  <= `CTM_TW_RESET;
        end else begin
            case (hold_st_q)
                HOLD_IDLE: begin
                    if (update_evt && hold_now) begin
                        // hold-off of one moves at once
                        active_q <= shadow_q;
                    end else if (update_evt) begin
                        hold_q    <= HOLDOFF;
                        hold_st_q <= HOLD_COUNT;
                    end
                end
                HOLD_COUNT: begin
                    if (update_evt && hold_now) begin
                        active_q  <= shadow_q;
                        hold_st_q <= HOLD_IDLE;
                    end else if (update_evt) begin
                        hold_q <= HOLDOFF;
                    end else if (hold_done) begin
                        active_q  <= shadow_q;
                        hold_st_q <= HOLD_IDLE;
                    end else if (IN_VALID) begin
                        hold_q <= hold_q - 1'b1;
                    end
                end
                default: begin
                    hold_st_q <= HOLD_IDLE;
                end
            endcase
        end
    end

    // accumulator advance with optional phase dither
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            acc_q <= '0;
        end else if (HOP_SYNC && CLEAR_ACC) begin
            // clear before the hop; offset still applies
            acc_q <= '0;
        end else if (IN_VALID) begin
            acc_q <= acc_q + active_q +
                     (PHASE_DITHER_EN ?
                      `CTM_TW_W'(lfsr_q[`CTM_PH_LSB-1:0]) : '0);
        end
    end

    // pseudorandom generator for source and dither
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lfsr_q <= `CTM_LFSR_SEED;
        end else if (IN_VALID) begin
            lfsr_q <= {lfsr_q[`CTM_LFSR_W-2:0], lfsr_fb};
        end
    end

    // selected sample register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_i_q   <= '0;
            s_q_q   <= '0;
            s_exp_q <= '0;
            s_cpx_q <= 1'b0;
            s_vld_q <= 1'b0;
        end else begin
            s_vld_q <= IN_VALID;
            if (IN_VALID) begin
                s_i_q   <= sel_i.mag;
                s_q_q   <= sel_q.mag;
                s_exp_q <= sel_i.exp;
                s_cpx_q <= sel_cpx;
            end
        end
    end

    // mixer output register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mix_q     <= '0;
            mix_vld_q <= 1'b0;
            mix_exp_q <= '0;
        end else begin
            mix_vld_q <= s_vld_q;
            if (s_vld_q) begin
                mix_q     <= mix_d;
                mix_exp_q <= s_exp_q;
            end
        end
    end

    logic vld_i;

    ctm_cic #(
        .IW (XW),
        .OW (XW),
        .N  (5),
        .DW (`CTM_DEC_W)
    ) u_cic_i (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .IN_VALID  (mix_vld_q),
        .IN_DATA   (mix_q.i),
        .DECIM_M1  (CIC_DECIM),
        .SCALE     (CIC_SCALE),
        .BYPASS    (CIC_BYPASS),
        .OUT_VALID (vld_i),
        .OUT_DATA  (OUT_IQ.i)
    );

    ctm_cic #(
        .IW (XW),
        .OW (XW),
        .N  (5),
        .DW (`CTM_DEC_W)
    ) u_cic_q (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .IN_VALID  (mix_vld_q),
        .IN_DATA   (mix_q.q),
        .DECIM_M1  (CIC_DECIM),
        .SCALE     (CIC_SCALE),
        .BYPASS    (CIC_BYPASS),
        .OUT_VALID (),
        .OUT_DATA  (OUT_IQ.q)
    );

    // status outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OUT_EXP <= '0;
        end else if (mix_vld_q) begin
            OUT_EXP <= mix_exp_q;
        end
    end

    assign OUT_VALID          = vld_i;
    assign ACTIVE_TUNING_WORD = active_q;
    assign UPDATE_PENDING     = hold_st_q == HOLD_COUNT;
endmodule : ctm_channel

// file: rtl/ctm_defines.svh
// numeric constants for the channel tuner, mixer and comb decimator
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

`define CTM_TW_W        32
`define CTM_PH_W        20
`define CTM_PH_LSB      12
`define CTM_OFS_W       16
`define CTM_OFS_PAD     4'h0
`define CTM_LUT_W       18
`define CTM_AMP_W       17
`define CTM_AMP_MAX     17'h0fffc
`define CTM_HALF_TURN   18'h20000
`define CTM_QTR_TURN    18'h10000
`define CTM_ADITH_W     2
`define CTM_HOLD_W      16
`define CTM_HOLD_ONE    16'h0001
`define CTM_DEC_W       5
`define CTM_DEC_MIN     5'h01
`define CTM_SCALE_MAX   5'h14
`define CTM_SCALE_BASE  6'h05
`define CTM_MAG_W       16
`define CTM_EXP_W       3
`define CTM_MIX_W       18
`define CTM_MIX_LSB     16
`define CTM_SEL_W       3
`define CTM_SEL_A       3'h0
`define CTM_SEL_B       3'h1
`define CTM_SEL_C       3'h2
`define CTM_SEL_D       3'h3
`define CTM_SEL_PN      3'h4
`define CTM_SEL_CPX_AB  3'h0
`define CTM_SEL_CPX_CD  3'h1
`define CTM_SEL_CPX_PN  3'h2
`define CTM_LFSR_W      16
`define CTM_LFSR_SEED   16'hace1
`define CTM_LFSR_TAPS   16'hb400
`define CTM_TW_RESET    32'h00000000

`endif

// file: rtl/ctm_pkg.sv
// types shared by the channel tuner and its comb decimator
package ctm_pkg;
    `include "ctm_defines.svh"

    typedef struct packed {
        logic signed [`CTM_MAG_W-1:0] mag;
        logic        [`CTM_EXP_W-1:0] exp;
    } ctm_port_s;

    typedef struct packed {
        logic signed [`CTM_MIX_W-1:0] i;
        logic signed [`CTM_MIX_W-1:0] q;
    } ctm_iq_s;

    typedef enum logic {
        HOLD_IDLE,
        HOLD_COUNT
    } ctm_hold_e;
endpackage : ctm_pkg

// file: rtl/ctm_cic.sv
// fifth-order decimating comb filter for one rail
`timescale 1ns/1ns
`include "ctm_defines.svh"
module ctm_cic #(
    parameter int IW = 18,
    parameter int OW = 18,
    parameter int N  = 5,
    parameter int DW = 5
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 IN_VALID,
    input  wire logic signed [IW-1:0] IN_DATA,
    input  wire logic        [DW-1:0] DECIM_M1,
    input  wire logic        [4:0]    SCALE,
    input  wire logic                 BYPASS,
    output logic                      OUT_VALID,
    output logic signed [OW-1:0]      OUT_DATA
);
    import ctm_pkg::*;
    localparam int W = IW + N * DW;

    logic signed [W-1:0]  integ_q [N];
    logic signed [W-1:0]  comb_q  [N];
    logic signed [W-1:0]  dly_q   [N];
    logic        [DW-1:0] cnt_q;
    logic                 tick_q;
    logic                 tick;
    logic        [DW-1:0] dec_lim;
    logic        [4:0]    scale_c;
    logic signed [W-1:0]  shifted;

    // a ratio of one exists only through bypass, so zero counts as two
    assign dec_lim = (DECIM_M1 < `CTM_DEC_MIN) ? `CTM_DEC_MIN : DECIM_M1;
    assign tick    = IN_VALID && (cnt_q >= dec_lim);
    // scale settings above 20 act as 20, a shift of 25
    assign scale_c = (SCALE > `CTM_SCALE_MAX) ? `CTM_SCALE_MAX : SCALE;
    assign shifted = comb_q[N-1] >>> ({1'b0, scale_c} + `CTM_SCALE_BASE);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
            if (IN_VALID) begin
                cnt_q <= tick ? '0 : cnt_q + 1'b1;
            end
        end
    end

    // integrators at input rate, combs at output rate
    for (genvar k = 0; k < N; k++) begin : g_stage
        localparam int KP = (k == 0) ? 0 : k - 1; // previous stage
        always_ff @(posedge CLK) begin
            if (!RST_N) begin
                integ_q[k] <= '0;
                comb_q[k]  <= '0;
                dly_q[k]   <= '0;
            end else begin
                if (IN_VALID) begin
                    if (k == 0) begin
                        integ_q[k] <= integ_q[k] + W'(IN_DATA);
                    end else begin
                        integ_q[k] <= integ_q[k] + integ_q[KP];
                    end
                end
                if (tick) begin
                    if (k == 0) begin
                        dly_q[k]  <= integ_q[N-1];
                        comb_q[k] <= integ_q[N-1] - dly_q[k];
                    end else begin
                        dly_q[k]  <= comb_q[KP];
                        comb_q[k] <= comb_q[KP] - dly_q[k];
                    end
                end
            end
        end
    end

    // output register; bypass passes samples unscaled
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OUT_VALID <= 1'b0;
            OUT_DATA  <= '0;
        end else if (BYPASS) begin
            OUT_VALID <= IN_VALID;
            OUT_DATA  <= OW'(IN_DATA);
        end else begin
            OUT_VALID <= tick_q;
            if (tick_q) begin
                OUT_DATA <= shifted[OW-1:0];
            end
        end
    end
endmodule : ctm_cic

// file: verif/ctm_monitor.sv
// assertion checker for the channel tuner ports
`timescale 1ns/1ns
module ctm_monitor (
    input wire logic               CLK,
    input wire logic               RST_N,
    input wire logic               IN_VALID,
    input wire ctm_pkg::ctm_port_s PORT_A,
    input wire logic               COMPLEX_INPUT,
    input wire logic [2:0]         XBAR_SEL,
    input wire logic               TUNE_WR,
    input wire logic [31:0]        TUNE_WDATA,
    input wire logic [15:0]        HOLDOFF,
    input wire logic               OSC_BYPASS,
    input wire logic               SLEEP_EXIT,
    input wire logic               HOP_SYNC,
    input wire logic               CIC_BYPASS,
    input wire logic [31:0]        ACTIVE_TUNING_WORD,
    input wire logic               UPDATE_PENDING,
    input wire logic               OUT_VALID,
    input wire ctm_pkg::ctm_iq_s   OUT_IQ,
    input wire logic [2:0]         OUT_EXP
);
    import ctm_pkg::*;
    logic [31:0] shadow_q;
    logic [15:0] cnt_q;
    logic [2:0]  lo_q;
    logic        ev;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // either update event
    assign ev = HOP_SYNC | SLEEP_EXIT;
    // mirror of shadow word, hold-off count and comb-on age
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shadow_q <= '0;
            cnt_q    <= '0;
            lo_q     <= '0;
        end else begin
            if (TUNE_WR) shadow_q <= TUNE_WDATA;
            if (ev) cnt_q <= HOLDOFF;
            else if (IN_VALID && cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
            lo_q <= CIC_BYPASS ? 3'h0 : (lo_q == 3'h7 ? lo_q : lo_q + 3'h1);
        end
    end
    property p_wr_shadow;
        $changed(ACTIVE_TUNING_WORD) |-> $past(ev) || $past(UPDATE_PENDING);
    endproperty
    a_wr_shadow: assert property (p_wr_shadow)
        else $error("active word moved without update");
    property p_hold_one;
        ev && HOLDOFF <= 16'h1 && !TUNE_WR |=>
            !UPDATE_PENDING && ACTIVE_TUNING_WORD == shadow_q;
    endproperty
    a_hold_one: assert property (p_hold_one)
        else $error("hold-off one not immediate");
    property p_pend_rise;
        ev && HOLDOFF > 16'h1 |=> UPDATE_PENDING;
    endproperty
    a_pend_rise: assert property (p_pend_rise)
        else $error("hold-off did not start");
    property p_pend_wait;
        UPDATE_PENDING && !IN_VALID && !ev |=>
            UPDATE_PENDING && $stable(ACTIVE_TUNING_WORD);
    endproperty
    a_pend_wait: assert property (p_pend_wait)
        else $error("hold-off moved without sample");
    property p_pend_done;
        UPDATE_PENDING && IN_VALID && !ev && !TUNE_WR && cnt_q == 16'h1
            |=> !UPDATE_PENDING && ACTIVE_TUNING_WORD == shadow_q;
    endproperty
    a_pend_done: assert property (p_pend_done)
        else $error("hold-off end missed");
    property p_comb_gap;
        OUT_VALID && !CIC_BYPASS && lo_q == 3'h7 |=> !OUT_VALID;
    endproperty
    a_comb_gap: assert property (p_comb_gap)
        else $error("comb output on adjacent cycles");
    property p_byp_lat;
        IN_VALID && CIC_BYPASS |-> ##3 (OUT_VALID || !CIC_BYPASS);
    endproperty
    a_byp_lat: assert property (p_byp_lat)
        else $error("bypassed sample missing");
    property p_byp_data;
        IN_VALID && CIC_BYPASS && OSC_BYPASS && !COMPLEX_INPUT
            && XBAR_SEL == 3'h0 |-> ##3
            OUT_IQ.i == $past(PORT_A.mag, 3) && OUT_IQ.q == '0;
    endproperty
    a_byp_data: assert property (p_byp_data)
        else $error("bypass data altered");
    property p_cpx_exp;
        IN_VALID && CIC_BYPASS && COMPLEX_INPUT && XBAR_SEL == 3'h0
            |-> ##3 OUT_EXP == $past(PORT_A.exp, 3);
    endproperty
    a_cpx_exp: assert property (p_cpx_exp)
        else $error("pair exponent wrong");
endmodule : ctm_monitor

bind ctm_channel ctm_monitor i_mon (.CLK, .RST_N, .IN_VALID, .PORT_A,
    .COMPLEX_INPUT, .XBAR_SEL, .TUNE_WR, .TUNE_WDATA, .HOLDOFF, .OSC_BYPASS,
    .SLEEP_EXIT, .HOP_SYNC, .CIC_BYPASS, .ACTIVE_TUNING_WORD,
    .UPDATE_PENDING, .OUT_VALID, .OUT_IQ, .OUT_EXP);

// file: verif/ctm_adc_model.sv
// converter model driving the four input ports
`timescale 1ns/1ns
module ctm_adc_model (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     run,
    input  wire logic [3:0]               gap,
    input  wire ctm_pkg::ctm_port_s [3:0] vals,
    output logic                          in_valid,
    output ctm_pkg::ctm_port_s [3:0]      ports
);
    import ctm_pkg::*;
    logic [3:0] wait_q;
    // one sample every gap+1 cycles while run is high
    always_ff @(negedge clk) begin
        if (!rst_n || !run) begin
            in_valid <= 1'b0;
            wait_q   <= 4'h0;
        end else begin
            in_valid <= (wait_q == 4'h0);
            wait_q   <= (wait_q == 4'h0) ? gap : wait_q - 4'h1;
        end
    end
    // data only holds while the strobe is high
    assign ports = in_valid ? vals : ~vals;
endmodule : ctm_adc_model

// file: verif/tb.sv
// self-checking bench for the channel tuner, mixer and comb decimator
`timescale 1ns/1ns
module tb;
    import ctm_pkg::*;
    typedef struct packed {
        logic        osc_byp;
        logic        cpx;
        logic [2:0]  sel;
        logic [15:0] ofs;
        logic [17:0] ei;
        logic [17:0] eq;
        logic [2:0]  ee;
    } ctm_row_s;
    localparam int NROW = 13;
    ctm_row_s rows [NROW] = '{
        '{1'b1, 1'b0, 3'h0, 16'h0000, 18'h04000, 18'h00000, 3'h1},
        '{1'b1, 1'b0, 3'h1, 16'h0000, 18'h3a000, 18'h00000, 3'h2},
        '{1'b1, 1'b0, 3'h2, 16'h0000, 18'h07fff, 18'h00000, 3'h3},
        '{1'b1, 1'b0, 3'h3, 16'h0000, 18'h3fff0, 18'h00000, 3'h4},
        '{1'b1, 1'b0, 3'h5, 16'h0000, 18'h00000, 18'h00000, 3'h0},
        '{1'b1, 1'b1, 3'h0, 16'h0000, 18'h04000, 18'h3a000, 3'h1},
        '{1'b1, 1'b1, 3'h1, 16'h0000, 18'h07fff, 18'h3fff0, 3'h3},
        '{1'b1, 1'b1, 3'h3, 16'h0000, 18'h00000, 18'h00000, 3'h0},
        '{1'b0, 1'b0, 3'h0, 16'h0000, 18'h04000, 18'h00000, 3'h1},
        '{1'b0, 1'b0, 3'h0, 16'h4000, 18'h00000, 18'h3c000, 3'h1},
        '{1'b0, 1'b1, 3'h0, 16'h0000, 18'h04000, 18'h3a000, 3'h1},
        '{1'b0, 1'b1, 3'h0, 16'h4000, 18'h3a000, 18'h3c000, 3'h1},
        '{1'b0, 1'b1, 3'h0, 16'h8000, 18'h3c000, 18'h06000, 3'h1}};
    logic               CLK = 1'b0;
    logic               RST_N = 1'b0;
    logic               run = 1'b0;
    logic               tune_wr = 1'b0;
    logic               hop_sync = 1'b0;
    logic               sleep_exit = 1'b0;
    logic               clr_acc = 1'b0;
    logic               cic_byp = 1'b1;
    logic               dith = 1'b1;
    logic [31:0]        tune_wdata = 32'h0;
    logic [15:0]        holdoff = 16'h1;
    logic [4:0]         decim = 5'h1;
    logic [4:0]         scale = 5'h0;
    ctm_row_s           cur = '0;
    ctm_port_s [3:0]    vals;
    ctm_port_s [3:0]    ports;
    logic               in_valid;
    logic               pending;
    logic               out_valid;
    logic [31:0]        active;
    ctm_iq_s            out_iq;
    ctm_iq_s            iq;
    ctm_iq_s            o [4];
    logic [2:0]         out_exp;
    logic [2:0]         ex;
    logic signed [17:0] last_i;
    int                 n_fail = 0;
    int                 n_compared = 0;
    int                 out_cnt = 0;
    int                 tol;

    assign vals = {{16'hfff0, 3'h4}, {16'h7fff, 3'h3}, {16'ha000, 3'h2},
                   {16'h4000, 3'h1}};
    always #20 CLK = ~CLK;

    ctm_adc_model i_adc (.clk(CLK), .rst_n(RST_N), .run(run), .gap(4'h0),
        .vals(vals), .in_valid(in_valid), .ports(ports));
    ctm_channel i_dut (.CLK(CLK), .RST_N(RST_N), .IN_VALID(in_valid),
        .PORT_A(ports[0]), .PORT_B(ports[1]), .PORT_C(ports[2]),
        .PORT_D(ports[3]), .COMPLEX_INPUT(cur.cpx), .XBAR_SEL(cur.sel),
        .TUNE_WR(tune_wr), .TUNE_WDATA(tune_wdata), .HOLDOFF(holdoff),
        .PHASE_OFFSET(cur.ofs), .OSC_BYPASS(cur.osc_byp),
        .CLEAR_ACC(clr_acc), .PHASE_DITHER_EN(dith), .AMP_DITHER_EN(dith),
        .SLEEP_EXIT(sleep_exit), .HOP_SYNC(hop_sync), .CIC_DECIM(decim),
        .CIC_SCALE(scale), .CIC_BYPASS(cic_byp),
        .ACTIVE_TUNING_WORD(active), .UPDATE_PENDING(pending),
        .OUT_VALID(out_valid), .OUT_IQ(out_iq), .OUT_EXP(out_exp));

    // counts outputs and keeps the I value of the last one
    always @(posedge CLK) begin
        if (out_valid === 1'b1) begin
            out_cnt <= out_cnt + 1;
            last_i  <= out_iq.i;
        end
    end

    function automatic logic near(input logic signed [17:0] a,
                                  input logic signed [17:0] b, input int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction : near

    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic feed(input int n);
        @(negedge CLK);
        run <= 1'b1;
        repeat (n) @(negedge CLK);
        run <= 1'b0;
    endtask : feed

    task automatic pulse(ref logic s);
        @(negedge CLK);
        s = 1'b1;
        @(negedge CLK);
        s = 1'b0;
    endtask : pulse

    task automatic get_out(output ctm_iq_s v, output logic [2:0] e);
        int k = 0;
        do begin
            @(posedge CLK);
            #1;
            k++;
        end while (out_valid !== 1'b1 && k < 50);
        check(k < 50, "no output");
        v = out_iq;
        e = out_exp;
    endtask : get_out

    task automatic print_verdict();
        $display("TB: compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // cuts a hang short
    initial begin
        repeat (5000) @(posedge CLK);
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (12) @(negedge CLK);
        RST_N = 1'b1;
        for (int r = 0; r < NROW; r++) begin
            @(negedge CLK);
            cur = rows[r];
            tol = cur.osc_byp ? 0 : 8;
            feed(1);
            get_out(iq, ex);
            check(near(iq.i, cur.ei, tol), "row i");
            check(near(iq.q, cur.eq, tol), "row q");
            check(ex === cur.ee, "row exponent");
        end
        @(negedge CLK);
        cur = rows[8];
        tune_wdata = 32'h8000_0000;
        pulse(tune_wr);
        repeat (3) @(negedge CLK);
        check(active === 32'h0, "write reached active");
        clr_acc = 1'b1;
        dith = 1'b0;
        pulse(hop_sync);
        check(active === 32'h8000_0000, "hold-off one");
        fork
            feed(4);
            for (int k = 0; k < 4; k++) get_out(o[k], ex);
        join
        check(near(o[0].i, 18'h04000, 8) || near(o[0].i, 18'h3c000, 8),
              "half turn level");
        for (int k = 0; k < 3; k++) begin
            check(near(o[k].i, -o[k+1].i, 0),
                  "half turn step");
        end
        @(negedge CLK);
        tune_wdata = 32'h4000_0000;
        pulse(tune_wr);
        holdoff = 16'h3;
        pulse(sleep_exit);
        check(pending === 1'b1 && active === 32'h8000_0000, "start");
        feed(2);
        repeat (2) @(negedge CLK);
        check(pending === 1'b1 && active === 32'h8000_0000, "early");
        feed(1);
        @(negedge CLK);
        check(pending === 1'b0 && active === 32'h4000_0000, "done");
        cur = rows[4];
        cur.sel = 3'h4;
        fork
            feed(2);
            for (int k = 0; k < 2; k++) get_out(o[k], ex);
        join
        check(o[0].i != o[1].i, "pseudorandom stuck");
        @(negedge CLK);
        cur = rows[0];
        cic_byp = 1'b0;
        for (int t = 0; t < 2; t++) begin
            decim = t ? 5'h1f : 5'h01;
            scale = t ? 5'h14 : 5'h00;
            feed(32);
            repeat (8) @(negedge CLK);
            out_cnt = 0;
            feed(t ? 384 : 24);
            repeat (8) @(negedge CLK);
            check(out_cnt == 12, "comb rate");
            check(last_i === 18'sh04000, "comb gain");
        end
        RST_N = 1'b0;
        repeat (2) @(negedge CLK);
        check(active === 32'h0 && pending === 1'b0 && out_valid === 1'b0
              && out_iq === '0 && out_exp === 3'h0, "reset state");
        RST_N = 1'b1;
        print_verdict();
    end
endmodule : tb
